//--- rtl/dbc_break_control.sv
// Breakpoint control of the serial debug interface: register writes, comparators, break state.
//
// Function
// - Clearing the next-break bit releases the CPU from its break.
// - While the next-break bit is set, break on the next instruction.
// - Breaks happen only at an instruction's first opcode byte.
// - Clock pin high and data pin low at reset end sets next-break.
// - An enabled comparator hit sets the next-break bit automatically.
// - Writing 1 to the next-break bit forces a break request.
// - Bits 6 to 3 enable comparators 3 to 0; zero disables.
// - Without page mode, comparators 0 and 1 compare all 24 address bits.
// - Bit 2 makes comparator 1 match on address bits 23 to 8.
// - Bit 1 makes comparator 0 match on address bits 23 to 8.
// - Single-step bit set breaks after every executed instruction.
// - Break control sits at write-only debug address 10h, never read back.
// - Compared address is base register plus low 16 bits unless wide mode.
// - A hit off an instruction start breaks after that instruction ends.
`timescale 1ns/100ps
module dbc_break_control (
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     link_clk,
    input  wire logic                     link_wr,
    input  wire dbc_pkg::dbc_reg_write_t  link_wr_bus,
    output logic                          link_busy,
    input  wire logic                     debug_clock_pin,
    input  wire logic                     debug_data_pin,
    input  wire dbc_pkg::dbc_cpu_bus_t    cpu_bus,
    output logic                          cpu_halt,
    output logic                          break_armed,
    output logic                          in_break
);
    import dbc_pkg::*;

    // Link domain signals.
    logic                 link_rst;
    logic                 link_req_tog_reg;
    logic                 link_ack_sync;
    dbc_reg_write_t       link_hold_reg;

    // Core domain signals.
    logic                 core_req_sync;
    logic                 core_ack_tog_reg;
    logic                 host_wr;
    logic                 ctl_wr;
    logic                 match_wr;
    logic [1:0]           match_index;
    logic [1:0]           match_byte;
    logic [1:0]           pins_sync;
    logic                 srst_d_reg;
    logic                 strap_break;
    dbc_break_control_t   ctl_reg;
    dbc_break_control_t   ctl_next;
    logic [23:0]          match_value_reg [DBC_MATCH_COUNT];
    logic [23:0]          cmp_addr;
    logic [3:0]           match_enable;
    logic [3:0]           match_page;
    logic [3:0]           cmp_hit;
    logic                 any_hit;
    logic                 fetch_first;
    logic                 hit_first;
    logic                 hit_operand;
    logic                 pend_reg;
    logic                 skip_reg;
    logic                 set_next;
    logic                 defer_set;
    logic                 step_set;
    logic                 halt_now;
    dbc_state_t           state_reg;
    dbc_state_t           state_next;

    // ------------------------------------------------------------------
    // Link clock side. A write is parked in a holding register and
    // announced by a toggle. The holding register stays still until the
    // core has acknowledged, which makes it safe to read across domains.
    // ------------------------------------------------------------------
    dbc_sync #(
        .WIDTH (1)
    ) u_link_rst_sync (
        .clk (link_clk),
        .rst (1'b0),
        .d   (srst),
        .q   (link_rst)
    );

    dbc_sync #(
        .WIDTH (1)
    ) u_ack_sync (
        .clk (link_clk),
        .rst (link_rst),
        .d   (core_ack_tog_reg),
        .q   (link_ack_sync)
    );

    // Writes offered while a previous one is still in flight are dropped.
    // A write offered while the link side is still held in reset would be
    // lost as well, so busy is shown then too and the host waits instead.
    assign link_busy = (link_req_tog_reg ^ link_ack_sync) || link_rst;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_req_tog_reg <= 1'b0;
        end else if (link_wr && !link_busy) begin
            link_req_tog_reg <= ~link_req_tog_reg;
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            link_hold_reg <= '0;
        end else if (link_wr && !link_busy) begin
            link_hold_reg <= link_wr_bus;
        end
    end

    // ------------------------------------------------------------------
    // Core clock side of the write crossing.
    // ------------------------------------------------------------------
    dbc_sync #(
        .WIDTH (1)
    ) u_req_sync (
        .clk (core_clk),
        .rst (srst),
        .d   (link_req_tog_reg),
        .q   (core_req_sync)
    );

    // The ack toggle copies the synced request one edge later, which turns
    // each request toggle into a single-cycle write pulse.
    assign host_wr = core_req_sync ^ core_ack_tog_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            core_ack_tog_reg <= 1'b0;
        end else begin
            core_ack_tog_reg <= core_req_sync;
        end
    end

    // Address decode of the write-only space; other addresses belong to
    // other parts of the debug unit and are ignored here.
    always_comb begin
        match_index = link_hold_reg.addr[3:2];
        match_byte  = link_hold_reg.addr[1:0];
        ctl_wr      = 1'b0;
        match_wr    = 1'b0;
        if (!host_wr) begin
            ctl_wr = 1'b0;
        end else if (link_hold_reg.addr == DBC_BREAK_CONTROL_OFFSET) begin
            ctl_wr = 1'b1;
        end else if (link_hold_reg.addr > DBC_MATCH3_UPPER_OFFSET) begin
            match_wr = 1'b0;
        end else if (match_byte == DBC_MATCH_BYTE_LOW) begin
            match_wr = 1'b1;
        end else if (match_byte == DBC_MATCH_BYTE_HIGH) begin
            match_wr = 1'b1;
        end else if (match_byte == DBC_MATCH_BYTE_UPPER) begin
            match_wr = 1'b1;
        end
    end

    // Each byte lands on its own, so an enabled comparator can see a half
    // written value between two writes; the host should keep a comparator
    // disabled while it loads a new address into it.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < DBC_MATCH_COUNT; i++) begin
                match_value_reg[i] <= DBC_MATCH_RESET;
            end
        end else if (match_wr) begin
            if (match_byte == DBC_MATCH_BYTE_LOW) begin
                match_value_reg[match_index][7:0] <= link_hold_reg.data;
            end else if (match_byte == DBC_MATCH_BYTE_HIGH) begin
                match_value_reg[match_index][15:8] <= link_hold_reg.data;
            end else if (match_byte == DBC_MATCH_BYTE_UPPER) begin
                match_value_reg[match_index][23:16] <= link_hold_reg.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Strap sampling. The pin chain is not reset so that it carries the
    // real pin levels into the first cycle after release.
    // ------------------------------------------------------------------
    dbc_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .clk (core_clk),
        .rst (1'b0),
        .d   ({debug_clock_pin, debug_data_pin}),
        .q   (pins_sync)
    );

    always_ff @(posedge core_clk) begin
        srst_d_reg <= srst;
    end

    assign strap_break = srst_d_reg && !srst && pins_sync[1] && !pins_sync[0];

    // ------------------------------------------------------------------
    // Comparators.
    // ------------------------------------------------------------------
    always_comb begin
        // In narrow mode the program does not drive the upper address byte,
        // so the base register stands in for it.
        // compared address
        if (cpu_bus.wide_address_mode) begin
            cmp_addr = cpu_bus.addr;
        end else begin
            cmp_addr = {cpu_bus.upper_address_base, cpu_bus.addr[15:0]};
        end
        match_enable = {ctl_reg.match3_break_enable, ctl_reg.match2_break_enable,
                        ctl_reg.match1_break_enable, ctl_reg.match0_break_enable};
        match_page   = {2'b00, ctl_reg.page_match1, ctl_reg.page_match0};
    end

    for (genvar g = 0; g < DBC_MATCH_COUNT; g++) begin : g_cmp
        dbc_comparator u_cmp (
            .addr        (cmp_addr),
            .match_value (match_value_reg[g]),
            .enable      (match_enable[g]),
            .ignore_low  (match_page[g]),
            .hit         (cmp_hit[g])
        );
    end

    // Right after a release the CPU refetches the opcode it stopped on;
    // that one fetch is kept from matching, or the CPU could never leave
    // a breakpoint without the host first disabling it.
    always_comb begin
        fetch_first = cpu_bus.fetch_valid && cpu_bus.first_opcode;
        any_hit     = (|cmp_hit) && cpu_bus.fetch_valid && (state_reg == DBC_ST_RUN);
        hit_first   = any_hit && cpu_bus.first_opcode && !skip_reg;
        hit_operand = any_hit && !cpu_bus.first_opcode;
    end

    // The end of an instruction wins over a new operand hit in the same
    // cycle; the automatic set term picks that hit up by itself.
    // deferred operand hit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pend_reg <= 1'b0;
        end else if (cpu_bus.instr_done) begin
            pend_reg <= 1'b0;
        end else if (hit_operand) begin
            pend_reg <= 1'b1;
        end
    end

    // The release wins over a fetch in the same cycle, because that fetch
    // is the held opcode that the release is about to let go.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            skip_reg <= 1'b0;
        end else if (state_reg == DBC_ST_HALT && state_next == DBC_ST_RUN) begin
            skip_reg <= 1'b1;
        end else if (fetch_first) begin
            skip_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Break control register. Hardware sets of the next-break bit win
    // over a host write of 0 in the same cycle, so no event is lost.
    // ------------------------------------------------------------------
    always_comb begin
        // automatic set
        // An operand hit in the very last cycle of its instruction is taken
        // here directly, as the pending flag clears in that cycle.
        defer_set = cpu_bus.instr_done && (pend_reg || hit_operand);
        // Single step only counts instructions run while not halted.
        step_set  = cpu_bus.instr_done && ctl_reg.single_step && (state_reg == DBC_ST_RUN);
        set_next  = strap_break || hit_first || defer_set || step_set;
        ctl_next = ctl_reg;
        if (ctl_wr) begin
            ctl_next = dbc_break_control_t'(link_hold_reg.data);
        end
        if (set_next) begin
            ctl_next.next_break = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctl_reg <= dbc_break_control_t'(DBC_BREAK_CONTROL_RESET);
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------------
    // Break state.
    // ------------------------------------------------------------------
    // The strap also has to stop a fetch in the first cycle after reset,
    // while the next-break bit it sets is still on its way to the register.
    // break at first opcode
    assign halt_now = (state_reg == DBC_ST_RUN)
                      && (((ctl_reg.next_break || strap_break) && fetch_first)
                          || hit_first);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DBC_ST_RUN: begin
                if (halt_now) begin
                    state_next = DBC_ST_HALT;
                end
            end
            DBC_ST_HALT: begin
                if (!ctl_reg.next_break) begin
                    state_next = DBC_ST_RUN;
                end
            end
            default: begin
                state_next = DBC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= DBC_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // The halt request reaches the CPU in the cycle of the opcode fetch
    // itself, so the instruction is held before it executes.
    assign cpu_halt    = halt_now || (state_reg == DBC_ST_HALT);
    assign break_armed = ctl_reg.next_break;
    assign in_break    = (state_reg == DBC_ST_HALT);

endmodule : dbc_break_control

//--- rtl/dbc_comparator.sv
// One address comparator with optional low byte masking.
`timescale 1ns/100ps
module dbc_comparator (
    input  wire logic [23:0] addr,
    input  wire logic [23:0] match_value,
    input  wire logic        enable,
    input  wire logic        ignore_low,
    output logic             hit
);
    import dbc_pkg::*;

    logic upper_equal;
    logic low_equal;

    always_comb begin
        upper_equal = (addr[23:8] == match_value[23:8]);
        low_equal   = (addr[7:0] == match_value[7:0]);
        hit         = enable && upper_equal && (ignore_low || low_equal);
    end

endmodule : dbc_comparator

//--- rtl/dbc_pkg.sv
// Shared constants, register layout and carrier types of the debug break control block.
package dbc_pkg;

    // Debug register addresses in the write-only space.
    localparam logic [7:0]  DBC_BREAK_CONTROL_OFFSET = 8'h10;
    localparam logic [7:0]  DBC_MATCH0_LOW_OFFSET    = 8'h00;
    localparam logic [7:0]  DBC_MATCH3_UPPER_OFFSET  = 8'h0E;
    localparam logic [1:0]  DBC_MATCH_BYTE_LOW       = 2'h0;
    localparam logic [1:0]  DBC_MATCH_BYTE_HIGH      = 2'h1;
    localparam logic [1:0]  DBC_MATCH_BYTE_UPPER     = 2'h2;

    // Values after reset.
    localparam logic [7:0]  DBC_BREAK_CONTROL_RESET  = 8'h00;
    localparam logic [23:0] DBC_MATCH_RESET          = 24'h000000;

    // Geometry of the comparators.
    localparam int          DBC_MATCH_COUNT          = 4;
    localparam int          DBC_ADDR_WIDTH           = 24;
    localparam int          DBC_SYNC_STAGES          = 2;

    // Break control register, bit 7 down to bit 0.
    typedef struct packed {
        logic next_break;
        logic match3_break_enable;
        logic match2_break_enable;
        logic match1_break_enable;
        logic match0_break_enable;
        logic page_match1;
        logic page_match0;
        logic single_step;
    } dbc_break_control_t;

    // One register write as delivered by the serial debug interface.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dbc_reg_write_t;

    // Instruction fetch view of the CPU.
    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  upper_address_base;
        logic        wide_address_mode;
        logic        fetch_valid;
        logic        first_opcode;
        logic        instr_done;
    } dbc_cpu_bus_t;

    typedef enum logic [1:0] {
        DBC_ST_RUN  = 2'b01,
        DBC_ST_HALT = 2'b10
    } dbc_state_t;

endpackage : dbc_pkg

//--- rtl/dbc_sync.sv
// Two flip-flop level synchroniser, one chain per bit.
`timescale 1ns/100ps
module dbc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import dbc_pkg::*;

    // The first stage is read only by the second stage.
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule : dbc_sync

//--- tb/dbc_break_control_asserts.sv
// Port level checks of the debug break control block.
`timescale 1ns/100ps
module dbc_break_control_asserts (
    input wire logic                    core_clk,
    input wire logic                    srst,
    input wire logic                    link_clk,
    input wire logic                    link_wr,
    input wire logic                    link_busy,
    input wire logic                    debug_clock_pin,
    input wire logic                    debug_data_pin,
    input wire dbc_pkg::dbc_cpu_bus_t   cpu_bus,
    input wire logic                    cpu_halt,
    input wire logic                    break_armed,
    input wire logic                    in_break
);
    import dbc_pkg::*;
    sequence s_first_fetch;
        cpu_bus.fetch_valid && cpu_bus.first_opcode;
    endsequence
    sequence s_armed_fetch;
        break_armed ##0 s_first_fetch;
    endsequence
    a_armed_halt: assert property (@(posedge core_clk) disable iff (srst)
        s_armed_fetch |-> cpu_halt) else $error("armed fetch not halted");
    a_halt_enter: assert property (@(posedge core_clk) disable iff (srst)
        s_armed_fetch |=> in_break) else $error("break state not entered");
    a_halt_opcode: assert property (@(posedge core_clk) disable iff (srst)
        $rose(cpu_halt) |-> s_first_fetch) else $error("halt off an opcode start");
    a_release_run: assert property (@(posedge core_clk) disable iff (srst)
        in_break && !break_armed |=> !in_break) else $error("break not released");
    a_halt_stands: assert property (@(posedge core_clk) disable iff (srst)
        in_break && break_armed |=> in_break) else $error("break left while armed");
    a_reset_clear: assert property (@(posedge core_clk)
        srst |=> !break_armed && !in_break) else $error("reset left break bits");
    a_strap_arm: assert property (@(posedge core_clk) disable iff (srst)
        $fell(srst) && debug_clock_pin && !debug_data_pin |-> ##[1:3] break_armed)
        else $error("strap did not arm");
    a_strap_first: assert property (@(posedge core_clk) disable iff (srst)
        ($fell(srst) && debug_clock_pin && !debug_data_pin) ##0 s_first_fetch |-> cpu_halt)
        else $error("strap missed first fetch");
    a_busy_take: assert property (@(posedge link_clk) disable iff (srst)
        link_wr && !link_busy |=> link_busy) else $error("write not taken");
endmodule : dbc_break_control_asserts
bind dbc_break_control dbc_break_control_asserts u_asserts (.core_clk(core_clk), .srst(srst),
    .link_clk(link_clk), .link_wr(link_wr), .link_busy(link_busy), .cpu_bus(cpu_bus),
    .debug_clock_pin(debug_clock_pin), .debug_data_pin(debug_data_pin),
    .cpu_halt(cpu_halt), .break_armed(break_armed), .in_break(in_break));

//--- tb/dbc_break_control_tb_top.sv
// Self-checking bench of the debug break control block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, g); n_mismatch++; end end
module dbc_break_control_tb_top;
    import dbc_pkg::*;
    logic           core_clk, srst, link_clk, link_wr, link_busy;
    logic           debug_clock_pin, debug_data_pin, cpu_halt, break_armed, in_break;
    dbc_reg_write_t link_wr_bus;
    dbc_cpu_bus_t   cb;
    int             n_mismatch = 0;
    int             n_checks = 0;
    dbc_break_control DUT (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
        .link_wr(link_wr), .link_wr_bus(link_wr_bus), .link_busy(link_busy),
        .debug_clock_pin(debug_clock_pin), .debug_data_pin(debug_data_pin), .cpu_bus(cb),
        .cpu_halt(cpu_halt), .break_armed(break_armed), .in_break(in_break));
    dbc_host_model host (.link_clk(link_clk), .link_wr(link_wr), .link_wr_bus(link_wr_bus),
        .link_busy(link_busy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic cyc(input logic fv, input logic fo, input logic dn, input logic [23:0] a);
        @(posedge core_clk);
        cb.fetch_valid <= fv;
        cb.first_opcode <= fo;
        cb.instr_done <= dn;
        cb.addr <= a;
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'b0, 1'b0, 1'b0, 24'h000000);
        host.write_reg(a, d);
        `CHK("link idle", 1'b0, link_busy)
        repeat (2) cyc(1'b0, 1'b0, 1'b0, 24'h000000);
    endtask : wr
    task automatic do_reset(input logic cp, input logic dp, input int n);
        @(posedge core_clk);
        srst <= 1'b1;
        debug_clock_pin <= cp;
        debug_data_pin <= dp;
        host.clk_on = 1'b1;
        repeat (n) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        host.clk_on = 1'b0;
        #1;
    endtask : do_reset
    task automatic t_reset();
        `CHK("armed", 1'b0, break_armed)
        `CHK("in_break", 1'b0, in_break)
        `CHK("halt", 1'b0, cpu_halt)
        `CHK("busy", 1'b0, link_busy)
        $display("test reset done");
    endtask : t_reset
    task automatic t_forced();
        wr(8'h03, 8'h80);
        `CHK("unmapped", 1'b0, break_armed)
        wr(DBC_BREAK_CONTROL_OFFSET, 8'h80);
        `CHK("forced arm", 1'b1, break_armed)
        cyc(1'b1, 1'b1, 1'b0, 24'h001000);
        `CHK("forced halt", 1'b1, cpu_halt)
        cyc(1'b0, 1'b0, 1'b0, 24'h000000);
        `CHK("in break", 1'b1, in_break)
        wr(DBC_BREAK_CONTROL_OFFSET, 8'h00);
        `CHK("released", 1'b0, in_break)
        `CHK("halt off", 1'b0, cpu_halt)
        $display("test forced done");
    endtask : t_forced
    task automatic match_try(input logic [7:0] ctl, input logic [23:0] a, input logic wide,
                             input logic [7:0] base, input logic exp, input string nm);
        @(posedge core_clk);
        cb.wide_address_mode <= wide;
        cb.upper_address_base <= base;
        wr(DBC_BREAK_CONTROL_OFFSET, 8'h00);
        cyc(1'b1, 1'b1, 1'b0, 24'hFFFFFF);
        wr(DBC_BREAK_CONTROL_OFFSET, ctl);
        cyc(1'b1, 1'b1, 1'b0, a);
        `CHK(nm, exp, cpu_halt)
        cyc(1'b0, 1'b0, 1'b0, 24'h000000);
        `CHK(nm, exp, in_break)
        `CHK(nm, exp, break_armed)
        $display("test %s done", nm);
    endtask : match_try
    task automatic t_match();
        logic [23:0] v;
        for (int x = 0; x < 4; x++) begin
            v = {8'hA0 + 8'(x), 8'h5C, 8'h30 + 8'(x)};
            wr(8'(4 * x), v[7:0]);
            wr(8'(4 * x + 1), v[15:8]);
            wr(8'(4 * x + 2), v[23:16]);
            match_try(8'h08 << x, v ^ 24'h000001, 1'b1, 8'h00, 1'b0, "full miss");
            match_try(8'h08 << x, v, 1'b1, 8'h00, 1'b1, "full hit");
        end
        match_try(8'h70, 24'hA05C30, 1'b1, 8'h00, 1'b0, "disabled");
        match_try(8'h0A, 24'hA05CEE, 1'b1, 8'h00, 1'b1, "page0 hit");
        match_try(8'h0A, 24'hA05D30, 1'b1, 8'h00, 1'b0, "page0 miss");
        match_try(8'h14, 24'hA15C00, 1'b1, 8'h00, 1'b1, "page1 hit");
        match_try(8'h10, 24'hA15C00, 1'b1, 8'h00, 1'b0, "page1 off");
        match_try(8'h26, 24'hA25C00, 1'b1, 8'h00, 1'b0, "page2 none");
        match_try(8'h20, 24'h335C32, 1'b0, 8'hA2, 1'b1, "narrow hit");
        match_try(8'h20, 24'h335C32, 1'b1, 8'hA2, 1'b0, "wide miss");
    endtask : t_match
    task automatic step_try(input logic [7:0] ctl, input logic [23:0] a, input logic exp,
                            input string nm);
        wr(DBC_BREAK_CONTROL_OFFSET, 8'h00);
        cyc(1'b1, 1'b1, 1'b0, 24'h000200);
        wr(DBC_BREAK_CONTROL_OFFSET, ctl);
        cyc(1'b1, 1'b1, 1'b0, 24'h000300);
        cyc(1'b1, 1'b0, 1'b0, a);
        `CHK(nm, 1'b0, cpu_halt)
        cyc(1'b1, 1'b0, 1'b1, 24'h000302);
        `CHK(nm, 1'b0, cpu_halt)
        cyc(1'b0, 1'b0, 1'b0, 24'h000000);
        `CHK(nm, exp, break_armed)
        cyc(1'b1, 1'b1, 1'b0, 24'h000303);
        `CHK(nm, exp, cpu_halt)
        $display("test %s done", nm);
    endtask : step_try
    task automatic t_strap();
        // The held opcode fetch stands through reset into the first cycle after it.
        cyc(1'b1, 1'b1, 1'b0, 24'h000400);
        do_reset(1'b1, 1'b0, 4);
        `CHK("strap arm", 1'b1, break_armed)
        cyc(1'b1, 1'b1, 1'b0, 24'h000000);
        `CHK("strap halt", 1'b1, cpu_halt)
        wr(DBC_BREAK_CONTROL_OFFSET, 8'h00);
        `CHK("strap release", 1'b0, in_break)
        $display("test strap done");
    endtask : t_strap
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    initial begin
        #300000;
        n_mismatch++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        srst = 1'b1;
        debug_clock_pin = 1'b0;
        debug_data_pin = 1'b1;
        cb = '0;
        host.clk_on = 1'b1;
        do_reset(1'b0, 1'b1, 1);
        t_reset();
        t_forced();
        t_match();
        step_try(8'h40, 24'hA35C33, 1'b1, "operand hit");
        step_try(8'h01, 24'h000301, 1'b1, "single step");
        step_try(8'h00, 24'hA35C33, 1'b0, "no step");
        t_strap();
        complete_run();
    end
endmodule : dbc_break_control_tb_top

//--- tb/dbc_host_model.sv
// Debug host model that offers register writes over the link and runs the link clock.
`timescale 1ns/100ps
module dbc_host_model (
    output logic                    link_clk,
    output logic                    link_wr,
    output dbc_pkg::dbc_reg_write_t link_wr_bus,
    input  wire logic               link_busy
);
    import dbc_pkg::*;
    logic clk_on = 1'b0;
    initial begin
        link_clk = 1'b0;
        link_wr = 1'b0;
        link_wr_bus = 16'h0000;
        #0.4;
        forever begin
            #3;
            // The link clock only runs while a write or a reset needs it, and stops low.
            if (clk_on || link_clk) link_clk = ~link_clk;
        end
    end
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        int n;
        clk_on = 1'b1;
        n = 0;
        @(posedge link_clk);
        while (link_busy !== 1'b0 && n < 50) begin
            @(posedge link_clk);
            n++;
        end
        link_wr <= 1'b1;
        link_wr_bus <= {a, d};
        @(posedge link_clk);
        link_wr <= 1'b0;
        // Released lines carry the inverse, so stale data cannot pass for a write.
        link_wr_bus <= ~link_wr_bus;
        n = 0;
        do begin
            @(posedge link_clk);
            n++;
        end while (link_busy !== 1'b0 && n < 50);
        clk_on = 1'b0;
    endtask : write_reg
endmodule : dbc_host_model
